// File: bench/bacp_host_model.sv
`timescale 1ns/1ns
// host side of the gauge: holds the alarm parameters it has programmed
module bacp_host_model (
  // soc thresholds, -1 disables
  output logic signed [7:0] tda_set_o,
  output logic signed [7:0] tda_clr_o,
  output logic signed [7:0] fd_set_o,
  output logic signed [7:0] fd_clr_o,
  output logic signed [7:0] tca_set_o,
  output logic signed [7:0] tca_clr_o,
  output logic signed [7:0] fc_set_o,
  output logic signed [7:0] fc_clr_o,
  // voltage alarms
  output logic [15:0]       da_level_o,
  output logic [15:0]       da_recovery_o,
  output logic [15:0]       ef_level_o,
  output logic [15:0]       ef_recovery_o,
  output logic [7:0]        da_dwell_o,
  output logic [7:0]        ef_dwell_o
);
  import bacp_pkg::*;
  task automatic set_soc(input logic signed [7:0] a, b, c, d, e, f, g, h);
    {tda_set_o, tda_clr_o, fd_set_o, fd_clr_o} = {a, b, c, d};
    {tca_set_o, tca_clr_o, fc_set_o, fc_clr_o} = {e, f, g, h};
  endtask : set_soc
  task automatic set_volt(input logic [15:0] tl, tr, fl, fr, input logic [7:0] tw, fw);
    {da_level_o, da_recovery_o, ef_level_o, ef_recovery_o} = {tl, tr, fl, fr};
    {da_dwell_o, ef_dwell_o} = {tw, fw};
  endtask : set_volt
  initial begin
    set_soc(BACP_TDA_SET_DEF, BACP_TDA_CLR_DEF, BACP_FD_SET_DEF, BACP_FD_CLR_DEF,
            BACP_TCA_SET_DEF, BACP_TCA_CLR_DEF, BACP_FC_SET_DEF, BACP_FC_CLR_DEF);
    // voltage alarms unused: level 0 never trips, recovery at top of range
    set_volt(16'h0000, 16'h3E80, 16'h0000, 16'h3E80, BACP_VDWELL_DEF, BACP_VDWELL_DEF);
  end
endmodule : bacp_host_model

// File: bench/bacp_top_tb.sv
`timescale 1ns/1ns
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin error_cnt++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, (got), (exp)); end end
module bacp_top_tb;
  import bacp_pkg::*;
  logic sys_clk_i, nrst_i, sleep_mode_i, discharging_i, relax_mode_i;
  logic reserve_rate_compensation_i, soc_alarm_source_select_i;
  logic [7:0] sleep_interval_i, load_mode_i, load_select_i;
  logic [7:0] relative_soc_i, absolute_soc_i, passed_pct_i;
  logic signed [15:0] current_i, avg_current_i, temperature_i, pulse_deviation_i;
  logic signed [15:0] at_rate_i, fixed_rate_current_i, fixed_rate_power_i;
  logic [15:0] voltage_i, dv_dt_uv_i, design_capacity_i, design_energy_i;
  logic [15:0] reserve_charge_i, reserve_energy_i;
  logic [63:0] cell_voltage_i;
  logic signed [31:0] last_run_current_i, last_run_power_i;
  logic signed [31:0] present_avg_current_i, present_avg_power_i;
  wire logic signed [7:0] tda_set_pct_i, tda_clr_pct_i, fd_set_pct_i, fd_clr_pct_i;
  wire logic signed [7:0] tca_set_pct_i, tca_clr_pct_i, fc_set_pct_i, fc_clr_pct_i;
  wire logic [15:0] discharge_alarm_voltage_level_i, discharge_alarm_voltage_recovery_i;
  wire logic [15:0] empty_flag_voltage_level_i, empty_flag_voltage_recovery_i;
  wire logic [7:0] discharge_alarm_voltage_dwell_i, empty_flag_voltage_dwell_i;
  logic tick_o, ocv_take_o, qmax_update_o, qmax_reject_o;
  logic term_discharge_alarm_o, fully_discharged_o, term_charge_alarm_o, fully_charged_o;
  logic signed [31:0] load_estimate_o, reserve_rate_o;
  logic [15:0] reserve_amount_o;
  logic signed [15:0] delta_voltage_o;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  bacp_host_model host_u (.tda_set_o(tda_set_pct_i), .tda_clr_o(tda_clr_pct_i),
    .fd_set_o(fd_set_pct_i), .fd_clr_o(fd_clr_pct_i), .tca_set_o(tca_set_pct_i),
    .tca_clr_o(tca_clr_pct_i), .fc_set_o(fc_set_pct_i), .fc_clr_o(fc_clr_pct_i),
    .da_level_o(discharge_alarm_voltage_level_i), .da_dwell_o(discharge_alarm_voltage_dwell_i),
    .da_recovery_o(discharge_alarm_voltage_recovery_i), .ef_level_o(empty_flag_voltage_level_i),
    .ef_dwell_o(empty_flag_voltage_dwell_i), .ef_recovery_o(empty_flag_voltage_recovery_i));
  // short tick and rest limit keep the run brief
  bacp_top #(.TICK_CYCLES(10), .REST_LIMIT_S(3)) dut_u (.*);
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  // ceiling well above the roughly 1000 cycles the tests need
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic wait_tick();
    int k = 0;
    do begin @(negedge sys_clk_i); k++; end while (tick_o !== 1'b1 && k < 200);
  endtask : wait_tick
  // results land on the edge after the tick, so look one falling edge later
  task automatic eval();
    wait_tick();
    @(negedge sys_clk_i);
  endtask : eval
  task automatic gap(input int exp);
    int n = 0;
    wait_tick();
    wait_tick();
    do begin @(negedge sys_clk_i); n++; end while (tick_o !== 1'b1 && n < 200);
    `CHK(n, exp)
  endtask : gap
  function automatic logic signed [31:0] est(input logic [7:0] s, input logic m);
    logic signed [31:0] v;
    v = {16'h0000, voltage_i};
    case (s)
      8'h00: est = m ? last_run_power_i : last_run_current_i;
      8'h01: est = m ? present_avg_power_i : present_avg_current_i;
      8'h02: est = m ? 32'(current_i) * v : 32'(current_i);
      8'h03: est = m ? 32'(avg_current_i) * v : 32'(avg_current_i);
      8'h04: est = m ? 32'(design_energy_i) / 5 : 32'(design_capacity_i) / 5;
      8'h05: est = 32'(at_rate_i);
      default: est = m ? 32'(fixed_rate_power_i) : 32'(fixed_rate_current_i);
    endcase
  endfunction : est
  task automatic t_load();
    logic signed [31:0] e;
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 7; s++) begin
        load_mode_i = 8'(m);
        load_select_i = 8'(s);
        e = est(8'(s), m[0]);
        eval();
        `CHK(load_estimate_o, e)
      end
    end
    load_select_i = 8'h07;
    eval();
    `CHK(load_estimate_o, e)
    load_mode_i = 8'h00;
    eval();
    `CHK(reserve_rate_o, 32'sh0)
    `CHK(reserve_amount_o, reserve_charge_i)
    load_mode_i = 8'h01;
    eval();
    `CHK(reserve_amount_o, reserve_energy_i)
    {load_mode_i, load_select_i, reserve_rate_compensation_i} = {8'h00, 8'h03, 1'b1};
    eval();
    eval();
    `CHK(reserve_rate_o, 32'(avg_current_i))
    $display("load test done");
  endtask : t_load
  task automatic soc(input logic [7:0] r, input logic [3:0] e);
    relative_soc_i = r;
    eval();
    `CHK({term_discharge_alarm_o, fully_discharged_o, term_charge_alarm_o, fully_charged_o}, e)
  endtask : soc
  task automatic t_soc();
    soc(8'h32, 4'h0);
    soc(8'h06, 4'h8);
    soc(8'h07, 4'h8);
    soc(8'h02, 4'hC);
    soc(8'h04, 4'hC);
    soc(8'h05, 4'h8);
    soc(8'h08, 4'h0);
    soc(8'h64, 4'h0);
    host_u.set_soc(8'sh06, 8'sh08, 8'sh02, 8'sh05, 8'sh61, 8'sh5F, 8'sh63, 8'sh62);
    soc(8'h61, 4'h2);
    soc(8'h63, 4'h3);
    soc(8'h62, 4'h2);
    soc(8'h5F, 4'h0);
    {soc_alarm_source_select_i, absolute_soc_i} = {1'b1, 8'h06};
    soc(8'h32, 4'h8);
    host_u.set_soc(8'sh06, 8'shFF, 8'sh02, 8'sh05, 8'sh61, 8'sh5F, 8'sh63, 8'sh62);
    absolute_soc_i = 8'h32;
    soc(8'h32, 4'h8);
    $display("soc test done");
  endtask : t_soc
  task automatic t_volt();
    host_u.set_soc(8'shFF, 8'shFF, 8'shFF, 8'shFF, 8'sh61, 8'sh5F, 8'sh63, 8'sh62);
    host_u.set_volt(16'h1388, 16'h157C, 16'h1388, 16'h1388, 8'h02, 8'h02);
    voltage_i = 16'h15E0;
    repeat (2) eval();
    `CHK({term_discharge_alarm_o, fully_discharged_o}, 2'b00)
    voltage_i = 16'h1324;
    eval();
    `CHK({term_discharge_alarm_o, fully_discharged_o}, 2'b00)
    repeat (3) eval();
    `CHK({term_discharge_alarm_o, fully_discharged_o}, 2'b11)
    voltage_i = 16'h1450;
    repeat (2) eval();
    `CHK({term_discharge_alarm_o, fully_discharged_o}, 2'b10)
    voltage_i = 16'h157C;
    repeat (2) eval();
    `CHK({term_discharge_alarm_o, fully_discharged_o}, 2'b00)
    $display("voltage test done");
  endtask : t_volt
  task automatic q_ep(input logic signed [15:0] t, input logic [7:0] p, input logic [15:0] c,
                      input logic [1:0] e);
    {temperature_i, passed_pct_i, cell_voltage_i} = {t, p, c, 48'h0E10_0E10_0E10};
    relax_mode_i = 1'b0;
    eval();
    relax_mode_i = 1'b1;
    eval();
    `CHK(ocv_take_o, 1'b1)
    eval();
    `CHK({qmax_update_o, qmax_reject_o}, e)
  endtask : q_ep
  task automatic t_qmax();
    logic seen = 1'b0;
    {relax_mode_i, dv_dt_uv_i} = {1'b1, 16'h0004};
    eval();
    `CHK(ocv_take_o, 1'b0)
    dv_dt_uv_i = 16'h0003;
    eval();
    `CHK(ocv_take_o, 1'b1)
    eval();
    `CHK(qmax_update_o, 1'b0)
    q_ep(16'sh00FA, 8'h32, 16'h0E10, 2'b10);
    q_ep(16'sh0191, 8'h32, 16'h0E10, 2'b01);
    q_ep(16'sh0190, 8'h32, 16'h0E10, 2'b10);
    q_ep(16'sh0063, 8'h32, 16'h0E10, 2'b01);
    q_ep(16'sh00FA, 8'h24, 16'h0E10, 2'b01);
    q_ep(16'sh00FA, 8'h25, 16'h0E10, 2'b10);
    q_ep(16'sh00FA, 8'h32, 16'h0E99, 2'b01);
    q_ep(16'sh00FA, 8'h32, 16'h0ED8, 2'b01);
    q_ep(16'sh00FA, 8'h32, 16'h0ED9, 2'b10);
    relax_mode_i = 1'b0;
    eval();
    {relax_mode_i, dv_dt_uv_i} = {1'b1, 16'h0064};
    eval();
    `CHK(ocv_take_o, 1'b0)
    repeat (5) begin eval(); seen = seen | ocv_take_o; end
    `CHK(seen, 1'b1)
    $display("qmax test done");
  endtask : t_qmax
  initial begin
    {nrst_i, sleep_mode_i, sleep_interval_i, discharging_i, relax_mode_i} = {2'b00, 8'h03, 2'b10};
    {load_mode_i, load_select_i, reserve_rate_compensation_i} = {16'h0000, 1'b0};
    {soc_alarm_source_select_i, relative_soc_i, absolute_soc_i} = {1'b0, 8'h32, 8'h32};
    {current_i, avg_current_i, voltage_i} = {16'sh0100, 16'sh00C8, 16'h2EE0};
    {temperature_i, dv_dt_uv_i, pulse_deviation_i} = {16'sh00FA, 16'h0000, 16'sh0000};
    {cell_voltage_i, passed_pct_i} = {64'h0E10_0E10_0E10_0E10, 8'h32};
    {last_run_current_i, last_run_power_i} = {32'sh0BB8, 32'sh2710};
    {present_avg_current_i, present_avg_power_i} = {32'sh07D0, 32'sh1F40};
    {design_capacity_i, design_energy_i, at_rate_i} = {16'h1130, 16'h1F40, 16'sh03E8};
    {fixed_rate_current_i, fixed_rate_power_i} = {16'sh09C4, 16'sh0FA0};
    {reserve_charge_i, reserve_energy_i} = {16'h0064, 16'h00C8};
    repeat (2) @(negedge sys_clk_i);
    nrst_i = 1'b1;
    `CHK({tick_o, ocv_take_o, term_discharge_alarm_o, fully_discharged_o}, 4'h0)
    `CHK(load_estimate_o, 32'sh0)
    gap(10);
    sleep_mode_i = 1'b1;
    gap(30);
    sleep_mode_i = 1'b0;
    $display("tick test done");
    foreach (pulse_deviation_i[i]) if (i < 4) begin
      pulse_deviation_i = (i == 1) ? 16'sh0032 : 16'sh001E;
      discharging_i = (i < 3);
      eval();
    end
    `CHK(delta_voltage_o, 16'sh0032)
    $display("delta test done");
    t_load();
    t_soc();
    t_volt();
    t_qmax();
    report_and_stop();
  end
endmodule : bacp_top_tb

// File: core/bacp_pkg.sv
package bacp_pkg;
  // load mode and selector encodings
  localparam logic [7:0] BACP_LOAD_MODE_CURRENT = 8'h00;
  localparam logic [7:0] BACP_LOAD_MODE_POWER   = 8'h01;
  localparam logic [7:0] BACP_SEL_LAST_RUN      = 8'h00;
  localparam logic [7:0] BACP_SEL_PRESENT_AVG   = 8'h01;
  localparam logic [7:0] BACP_SEL_INSTANT       = 8'h02;
  localparam logic [7:0] BACP_SEL_FILTERED      = 8'h03;
  localparam logic [7:0] BACP_SEL_DESIGN_FIFTH  = 8'h04;
  localparam logic [7:0] BACP_SEL_AT_RATE       = 8'h05;
  localparam logic [7:0] BACP_SEL_USER_RATE     = 8'h06;
  localparam int         BACP_DESIGN_DIVISOR    = 5;
  // soc thresholds are signed bytes, -1 disables
  localparam logic signed [7:0] BACP_SOC_DISABLED = 8'shFF;
  // qualification limits, temperature in 0.1 degC
  localparam logic signed [15:0] BACP_TEMP_MIN_DC  = 16'sh0064;
  localparam logic signed [15:0] BACP_TEMP_MAX_DC  = 16'sh0190;
  localparam logic [15:0]        BACP_CELL_BAND_LO = 16'h0E99;
  localparam logic [15:0]        BACP_CELL_BAND_HI = 16'h0ED8;
  localparam logic [7:0]         BACP_DELTA_PCT    = 8'h25;
  localparam logic [15:0]        BACP_RELAX_SLOPE_UV = 16'h0004;
  // rest timeout
  localparam int BACP_REST_LIMIT_HRS = 5;
  localparam int BACP_REST_LIMIT_S   = BACP_REST_LIMIT_HRS * 3600;
  // clock and tick
  localparam int BACP_CLK_HZ      = 10_000_000;
  localparam int BACP_TICK_S      = 1;
  localparam int BACP_TICK_CYCLES = BACP_CLK_HZ * BACP_TICK_S;
  // defaults
  localparam logic signed [7:0] BACP_TDA_SET_DEF = 8'sh06;
  localparam logic signed [7:0] BACP_TDA_CLR_DEF = 8'sh08;
  localparam logic signed [7:0] BACP_FD_SET_DEF  = 8'sh02;
  localparam logic signed [7:0] BACP_FD_CLR_DEF  = 8'sh05;
  localparam logic signed [7:0] BACP_TCA_SET_DEF = 8'shFF;
  localparam logic signed [7:0] BACP_TCA_CLR_DEF = 8'sh5F;
  localparam logic signed [7:0] BACP_FC_SET_DEF  = 8'shFF;
  localparam logic signed [7:0] BACP_FC_CLR_DEF  = 8'sh62;
  localparam logic [15:0] BACP_TDA_VLEVEL_DEF = 16'h1388;
  localparam logic [15:0] BACP_TDA_VREC_DEF   = 16'h157C;
  localparam logic [15:0] BACP_FD_VLEVEL_DEF  = 16'h1388;
  localparam logic [15:0] BACP_FD_VREC_DEF    = 16'h1388;
  localparam logic [7:0]  BACP_VDWELL_DEF     = 8'h05;

  // rest-qualification states, gray from idle to second; the return from second to first changes both bits
  typedef enum logic [1:0] {
    BACP_Q_IDLE   = 2'b00,
    BACP_Q_FIRST  = 2'b01,
    BACP_Q_ACTIVE = 2'b11,
    BACP_Q_SECOND = 2'b10
  } bacp_qstate_t;
endpackage : bacp_pkg

// File: core/bacp_top.sv
`timescale 1ns/1ns
// Functional notes
// - selector 0 uses previous discharge average current or power.
// - selector 1 uses present discharge running average current or power.
// - selector 2 uses instant current, or current times voltage in power mode.
// - selector 3 uses filtered average current, or times voltage in power mode.
// - selectors 4 to 6 use design/5, host at-rate, or stored user rate.
// - track largest pulse voltage deviation during discharge, in millivolts.
// - hold back configured reserve charge or energy before termination.
// - reserve compensated at no load when bit 0, at selected rate when 1.
// - full capacity update needs relaxed readings before and after activity.
// - relaxed when voltage slope falls below 4 microvolts.
// - rest beyond 5 hours forces the reading regardless of slope.
// - reject update when temperature outside 10 to 40 degrees.
// - reject update when passed capacity below 37 percent.
// - reject update when any cell voltage within 3737 to 3800 mV.
// - soc alarms use relative soc when select 0, absolute when 1.
// - discharge alarm and empty flag set at or below, clear at or above.
// - charge alarm and full flag set at or above, clear at or below.
// - threshold of -1 disables that soc action; range -1 to 100.
// - discharge alarm set by voltage dwell, cleared at recovery voltage.
// - empty flag set by voltage dwell, cleared at recovery voltage.
// - load mode 0 selects current, 1 selects power compensation.
// - decisions refresh every second, or at sleep interval in sleep mode.
module bacp_top #(
  parameter int TICK_CYCLES  = bacp_pkg::BACP_TICK_CYCLES,
  parameter int REST_LIMIT_S = bacp_pkg::BACP_REST_LIMIT_S
) (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  // mode
  input  wire logic        sleep_mode_i,
  input  wire logic [7:0]  sleep_interval_i,
  input  wire logic        discharging_i,
  input  wire logic        relax_mode_i,
  input  wire logic [7:0]  load_mode_i,
  input  wire logic [7:0]  load_select_i,
  input  wire logic        reserve_rate_compensation_i,
  input  wire logic        soc_alarm_source_select_i,
  // measurements
  input  wire logic signed [15:0] current_i,
  input  wire logic signed [15:0] avg_current_i,
  input  wire logic [15:0] voltage_i,
  input  wire logic signed [15:0] temperature_i,
  input  wire logic [63:0] cell_voltage_i,
  input  wire logic [15:0] dv_dt_uv_i,
  input  wire logic signed [15:0] pulse_deviation_i,
  input  wire logic [7:0]  relative_soc_i,
  input  wire logic [7:0]  absolute_soc_i,
  input  wire logic [7:0]  passed_pct_i,
  // stored figures
  input  wire logic signed [31:0] last_run_current_i,
  input  wire logic signed [31:0] last_run_power_i,
  input  wire logic signed [31:0] present_avg_current_i,
  input  wire logic signed [31:0] present_avg_power_i,
  input  wire logic [15:0] design_capacity_i,
  input  wire logic [15:0] design_energy_i,
  input  wire logic signed [15:0] at_rate_i,
  input  wire logic signed [15:0] fixed_rate_current_i,
  input  wire logic signed [15:0] fixed_rate_power_i,
  input  wire logic [15:0] reserve_charge_i,
  input  wire logic [15:0] reserve_energy_i,
  // thresholds
  input  wire logic signed [7:0] tda_set_pct_i,
  input  wire logic signed [7:0] tda_clr_pct_i,
  input  wire logic signed [7:0] fd_set_pct_i,
  input  wire logic signed [7:0] fd_clr_pct_i,
  input  wire logic signed [7:0] tca_set_pct_i,
  input  wire logic signed [7:0] tca_clr_pct_i,
  input  wire logic signed [7:0] fc_set_pct_i,
  input  wire logic signed [7:0] fc_clr_pct_i,
  input  wire logic [15:0] discharge_alarm_voltage_level_i,
  input  wire logic [7:0]  discharge_alarm_voltage_dwell_i,
  input  wire logic [15:0] discharge_alarm_voltage_recovery_i,
  input  wire logic [15:0] empty_flag_voltage_level_i,
  input  wire logic [7:0]  empty_flag_voltage_dwell_i,
  input  wire logic [15:0] empty_flag_voltage_recovery_i,
  // results
  output logic             tick_o,
  output logic signed [31:0] load_estimate_o,
  output logic signed [31:0] reserve_rate_o,
  output logic [15:0]      reserve_amount_o,
  output logic signed [15:0] delta_voltage_o,
  output logic             ocv_take_o,
  output logic             qmax_update_o,
  output logic             qmax_reject_o,
  output logic             term_discharge_alarm_o,
  output logic             fully_discharged_o,
  output logic             term_charge_alarm_o,
  output logic             fully_charged_o
);
  import bacp_pkg::*;

  // refused at elaboration: a divider below two cycles cannot make a one-cycle tick
  if (TICK_CYCLES < 2 || REST_LIMIT_S < 1) begin : g_bad_param
    $error("bacp_top: bad parameters");
  end

  typedef struct packed {
    logic [31:0]        div;
    logic [7:0]         sleep_cnt;
    logic               tick;
    logic signed [31:0] load_est;
    logic signed [31:0] res_rate;
    logic [15:0]        res_amt;
    logic signed [15:0] dv;
    bacp_qstate_t       qst;
    logic [31:0]        rest_s;
    logic               ocv;
    logic               upd;
    logic               rej;
    logic               tda;
    logic               fd;
    logic               tca;
    logic               fc;
  } bacp_state_t;
  bacp_state_t state_reg, state_next;

  logic tda_vset, tda_vclr, fd_vset, fd_vclr;

  function automatic logic bacp_le(input logic [7:0] soc, input logic signed [7:0] th);
    bacp_le = (th != BACP_SOC_DISABLED) && ($signed({1'b0, soc}) <= 9'(th));
  endfunction : bacp_le

  function automatic logic bacp_ge(input logic [7:0] soc, input logic signed [7:0] th);
    bacp_ge = (th != BACP_SOC_DISABLED) && ($signed({1'b0, soc}) >= 9'(th));
  endfunction : bacp_ge

  function automatic logic signed [31:0] bacp_mul(input logic signed [15:0] i,
                                                  input logic [15:0] v);
    bacp_mul = 32'(i * $signed({1'b0, v}));
  endfunction : bacp_mul

  logic       pwr;
  logic [7:0] soc;
  logic       cell_in_band;
  logic       temp_bad;
  logic       relaxed;
  always_comb begin
    pwr = (load_mode_i == BACP_LOAD_MODE_POWER);
    soc = soc_alarm_source_select_i ? absolute_soc_i : relative_soc_i;
    cell_in_band = 1'b0;
    for (int c = 0; c < 4; c++) begin
      if (cell_voltage_i[c*16 +: 16] >= BACP_CELL_BAND_LO &&
          cell_voltage_i[c*16 +: 16] <= BACP_CELL_BAND_HI) begin
        cell_in_band = 1'b1;
      end
    end
    temp_bad = temperature_i < BACP_TEMP_MIN_DC || temperature_i > BACP_TEMP_MAX_DC;
    relaxed = relax_mode_i && (dv_dt_uv_i < BACP_RELAX_SLOPE_UV ||
              state_reg.rest_s >= 32'(REST_LIMIT_S));
  end

  bacp_volt_alarm u_tda_volt (
    .sys_clk_i  (sys_clk_i),
    .nrst_i     (nrst_i),
    .tick_i     (state_reg.tick),
    .voltage_i  (voltage_i),
    .level_i    (discharge_alarm_voltage_level_i),
    .recovery_i (discharge_alarm_voltage_recovery_i),
    .dwell_i    (discharge_alarm_voltage_dwell_i),
    .set_o      (tda_vset),
    .clear_o    (tda_vclr)
  );

  bacp_volt_alarm u_fd_volt (
    .sys_clk_i  (sys_clk_i),
    .nrst_i     (nrst_i),
    .tick_i     (state_reg.tick),
    .voltage_i  (voltage_i),
    .level_i    (empty_flag_voltage_level_i),
    .recovery_i (empty_flag_voltage_recovery_i),
    .dwell_i    (empty_flag_voltage_dwell_i),
    .set_o      (fd_vset),
    .clear_o    (fd_vclr)
  );

  always_comb begin
    state_next = state_reg;
    state_next.tick = 1'b0;
    state_next.ocv = 1'b0;
    state_next.upd = 1'b0;
    state_next.rej = 1'b0;
    // one-second divider; in sleep, every sleep_interval seconds
    if (state_reg.div >= 32'(TICK_CYCLES - 1)) begin
      state_next.div = '0;
      if (!sleep_mode_i || state_reg.sleep_cnt + 8'h01 >= sleep_interval_i) begin
        state_next.tick = 1'b1;
        state_next.sleep_cnt = '0;
      end else begin
        state_next.sleep_cnt = state_reg.sleep_cnt + 8'h01;
      end
    end else begin
      state_next.div = state_reg.div + 32'h1;
    end

    if (state_reg.tick) begin
      case (load_select_i)
        BACP_SEL_LAST_RUN:
          state_next.load_est = pwr ? last_run_power_i : last_run_current_i;
        BACP_SEL_PRESENT_AVG:
          state_next.load_est = pwr ? present_avg_power_i : present_avg_current_i;
        BACP_SEL_INSTANT:
          state_next.load_est = pwr ? bacp_mul(current_i, voltage_i) : 32'(current_i);
        BACP_SEL_FILTERED:
          state_next.load_est = pwr ? bacp_mul(avg_current_i, voltage_i)
                                    : 32'(avg_current_i);
        BACP_SEL_DESIGN_FIFTH:
          state_next.load_est = 32'((pwr ? design_energy_i : design_capacity_i)
                                    / 16'(BACP_DESIGN_DIVISOR));
        BACP_SEL_AT_RATE:
          state_next.load_est = 32'(at_rate_i);
        BACP_SEL_USER_RATE:
          state_next.load_est = pwr ? 32'(fixed_rate_power_i)
                                    : 32'(fixed_rate_current_i);
        default:
          state_next.load_est = state_reg.load_est;
      endcase
      state_next.res_amt = pwr ? reserve_energy_i : reserve_charge_i;
      state_next.res_rate = reserve_rate_compensation_i ? state_reg.load_est : 32'sh0;
      if (discharging_i && pulse_deviation_i > state_reg.dv) begin
        state_next.dv = pulse_deviation_i;
      end

      // rest timer counts seconds in relaxation
      state_next.rest_s = relax_mode_i ? state_reg.rest_s + 32'h1 : 32'h0;
      case (state_reg.qst)
        BACP_Q_IDLE: begin
          if (relaxed) begin
            state_next.qst = BACP_Q_FIRST;
            state_next.ocv = 1'b1;
          end
        end
        BACP_Q_FIRST: begin
          if (!relax_mode_i) begin
            state_next.qst = BACP_Q_ACTIVE;
          end
        end
        BACP_Q_ACTIVE: begin
          if (relaxed) begin
            state_next.qst = BACP_Q_SECOND;
            state_next.ocv = 1'b1;
          end
        end
        BACP_Q_SECOND: begin
          // second reading also serves as the first of the next pair
          state_next.qst = BACP_Q_FIRST;
          if (temp_bad || passed_pct_i < BACP_DELTA_PCT || cell_in_band) begin
            state_next.rej = 1'b1;
          end else begin
            state_next.upd = 1'b1;
          end
        end
        default: state_next.qst = BACP_Q_IDLE;
      endcase

      // clear first then set, so a set in the same evaluation wins
      if (bacp_ge(soc, tda_clr_pct_i) || tda_vclr) state_next.tda = 1'b0;
      if (bacp_le(soc, tda_set_pct_i) || tda_vset) state_next.tda = 1'b1;
      if (bacp_ge(soc, fd_clr_pct_i) || fd_vclr) state_next.fd = 1'b0;
      if (bacp_le(soc, fd_set_pct_i) || fd_vset) state_next.fd = 1'b1;
      if (bacp_le(soc, tca_clr_pct_i)) state_next.tca = 1'b0;
      if (bacp_ge(soc, tca_set_pct_i)) state_next.tca = 1'b1;
      if (bacp_le(soc, fc_clr_pct_i)) state_next.fc = 1'b0;
      if (bacp_ge(soc, fc_set_pct_i)) state_next.fc = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tick_o                 = state_reg.tick;
  assign load_estimate_o        = state_reg.load_est;
  assign reserve_rate_o         = state_reg.res_rate;
  assign reserve_amount_o       = state_reg.res_amt;
  assign delta_voltage_o        = state_reg.dv;
  assign ocv_take_o             = state_reg.ocv;
  assign qmax_update_o          = state_reg.upd;
  assign qmax_reject_o          = state_reg.rej;
  assign term_discharge_alarm_o = state_reg.tda;
  assign fully_discharged_o     = state_reg.fd;
  assign term_charge_alarm_o    = state_reg.tca;
  assign fully_charged_o        = state_reg.fc;

  sequence second_reading_s;
    state_reg.qst == BACP_Q_SECOND && state_reg.tick;
  endsequence

  tick_pulse_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    tick_o |=> !tick_o) else $error("tick longer than one cycle");
  qmax_decide_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    second_reading_s |=> (qmax_update_o ^ qmax_reject_o))
    else $error("second reading without decision");
  temp_reject_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    second_reading_s and temp_bad |=> qmax_reject_o)
    else $error("update with bad temperature");
  delta_reject_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    second_reading_s and passed_pct_i < BACP_DELTA_PCT |=> qmax_reject_o)
    else $error("update with small delta");
  band_reject_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    second_reading_s and cell_in_band |=> qmax_reject_o)
    else $error("update with cell in band");
  dv_monotone_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    delta_voltage_o >= $past(delta_voltage_o)) else $error("delta voltage dropped");
  tda_set_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    state_reg.tick && bacp_le(soc, tda_set_pct_i) |=> term_discharge_alarm_o)
    else $error("discharge alarm not set");
  fc_hold_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    !state_reg.tick |=> $stable(fully_charged_o)) else $error("full flag moved off tick");
  sel_instant_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    state_reg.tick && load_select_i == BACP_SEL_INSTANT && !pwr
    |=> load_estimate_o == 32'($past(current_i))) else $error("instant estimate wrong");
  res_noload_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    state_reg.tick && !reserve_rate_compensation_i |=> reserve_rate_o == 32'sh0)
    else $error("reserve not at no load");
endmodule : bacp_top

// File: core/bacp_volt_alarm.sv
`timescale 1ns/1ns
// one voltage-qualified flag: set after dwell at or below level, clear at recovery
module bacp_volt_alarm (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  // evaluation
  input  wire logic        tick_i,
  input  wire logic [15:0] voltage_i,
  input  wire logic [15:0] level_i,
  input  wire logic [15:0] recovery_i,
  input  wire logic [7:0]  dwell_i,
  // result
  output logic             set_o,
  output logic             clear_o
);
  import bacp_pkg::*;
  typedef struct packed {
    logic [7:0] cnt;
    logic       set;
    logic       clr;
  } bacp_va_t;
  bacp_va_t state_reg, state_next;

  always_comb begin
    state_next = state_reg;
    if (tick_i) begin
      state_next.set = 1'b0;
      state_next.clr = voltage_i >= recovery_i;
      if (voltage_i <= level_i) begin
        // counts seconds below; dwell of zero sets at once
        if (state_reg.cnt + 8'h01 >= dwell_i) begin
          state_next.set = 1'b1;
          state_next.cnt = state_reg.cnt;
        end else begin
          state_next.cnt = state_reg.cnt + 8'h01;
        end
      end else begin
        state_next.cnt = 8'h00;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign set_o   = state_reg.set;
  assign clear_o = state_reg.clr;
endmodule : bacp_volt_alarm
